// ### ussu_map.vh
`ifndef USSU_MAP_VH
`define USSU_MAP_VH
// clock source select encodings
`define USSU_CS_NONE     2'h0
`define USSU_CS_TIMER    2'h1
`define USSU_CS_EXT      2'h2
`define USSU_CS_SOFT     2'h3
// wire mode encodings
`define USSU_WM_OFF      2'h0
`define USSU_WM_THREE    2'h1
`define USSU_WM_TWO      2'h2
`define USSU_WM_TWO_HOLD 2'h3
// reset values, counter constants and msb index
`define USSU_DATA_RST    8'h00
`define USSU_CNT_RST     4'h0
`define USSU_CNT_MAX     4'hf
`define USSU_CNT_ONE     4'h1
`define USSU_MSB         7
`endif

// ### ussu_sync.v
`timescale 1ns/10ps
// two flop synchroniser for a bundle of pin levels
module ussu_sync #(
    parameter WIDTH = 3
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_reg;  // first stage, read only by second stage
    reg [WIDTH-1:0] sync_reg;  // second stage, safe to use

    // both stages clear to zero on reset
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ### ussu_fifo.v
`timescale 1ns/10ps
// small synchronous fifo, valid/ready on both sides
module ussu_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage array
    reg [AW-1:0]    wr_ptr_reg;       // write index
    reg [AW-1:0]    rd_ptr_reg;       // read index
    reg [AW:0]      count_reg;        // fill level
    wire            push;
    wire            pop;

    assign o_in_ready  = (count_reg != DEPTH[AW:0]);
    assign o_out_valid = (count_reg != {(AW+1){1'b0}});
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem[rd_ptr_reg];

    // storage write, no reset needed on data
    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1 ||
                               DEPTH == (1 << AW) &&
                               wr_ptr_reg == {AW{1'b1}}) ?
                              {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1 ||
                               DEPTH == (1 << AW) &&
                               rd_ptr_reg == {AW{1'b1}}) ?
                              {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ### ussu_top.v
// Contract
// [R1] 8-bit shift register, direct access, unbuffered
// [R2] msb drives one of two pins
// [R3] output latch changes on opposite edge
// [R4] input always sampled from data-in pin
// [R5] readable writable 4-bit counter with overflow
// [R6] register and counter share one clock
// [R7] external clock counts both edges
// [R8] sources: pin, timer match, software strobe
// [R9] two-wire start condition raises flag
// [R10] two-wire hold clock low for waits
// [R11] three-wire spi modes 0/1, no select
// [R12] master and slave swap bytes in eight
// [R13] overflow after eight pulses sets flag
// [R14] master toggles clock by port or strobe
// [R15] edge select 0: sample rise, update fall
// [R16] edge select 1: sample fall, update rise
// [R17] load byte, counter zero before transfer
// [R18] output bit comes from written byte
// [R19] master clock pulse is two toggles
// [R20] process byte before next transfer
// [R21] overflow wakes the idle processor
// [R22] counter wraps fifteen to zero, flag same cycle
`timescale 1ns/10ps
`include "ussu_map.vh"
module ussu_top #(
    parameter DATA_W     = 8,
    parameter CNT_W      = 4,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire              i_clk,
    input  wire              i_rst_n,
    // control bits
    input  wire [1:0]        i_wire_mode,
    input  wire [1:0]        i_clock_source,
    input  wire              i_clock_edge_select_bit,
    input  wire              i_clock_strobe,
    input  wire              i_clock_toggle,
    input  wire              i_timer_match,
    input  wire              i_port_clock_toggle,
    // software access
    input  wire              i_data_wr,
    input  wire [DATA_W-1:0] i_data_wdata,
    output reg  [DATA_W-1:0] o_shift_data_reg,
    input  wire              i_cnt_wr,
    input  wire [CNT_W-1:0]  i_cnt_wdata,
    output reg  [CNT_W-1:0]  o_cnt,
    input  wire              i_ovf_clr,
    output reg               o_ovf_flag,
    input  wire              i_start_clr,
    output reg               o_start_flag,
    output reg               o_wake,
    // received byte stream
    output reg               o_rx_valid,
    input  wire              i_rx_ready,
    output reg  [DATA_W-1:0] o_rx_data,
    // pins
    input  wire              i_serial_data_in,
    input  wire              i_serial_clock_pin,
    output reg               o_serial_clock_pin,
    output reg               o_serial_clock_pin_oe,
    output reg               o_data_out,
    output reg               o_sda_out,
    output reg               o_sda_oe
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    ////////////////////////////////////////////////////////////////////////
    wire [1:0] pins_sync;       // {clock pin, data in}
    wire       sclk_s;          // synchronised clock pin
    wire       din_s;           // synchronised data-in
    reg        sclk_d_reg;      // previous clock level for edge finding
    reg        din_d_reg;       // previous data level, two-wire start
    wire       rise;
    wire       fall;

    ussu_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_serial_clock_pin, i_serial_data_in}),
        .o_sync  (pins_sync)
    );

    assign sclk_s = pins_sync[1];
    assign din_s  = pins_sync[0];  // [R4]
    assign rise   = sclk_s & ~sclk_d_reg;
    assign fall   = ~sclk_s & sclk_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // clock source decode
    ////////////////////////////////////////////////////////////////////////
    // sample strobe: the edge at which data-in is shifted in
    function sel_sample;
        input [1:0] src;
        input       es;
        input       r;
        input       f;
        input       tm;
        input       sw;
        begin
            case (src)
                `USSU_CS_EXT:   sel_sample = es ? f : r; // [R15] [R16]
                `USSU_CS_TIMER: sel_sample = tm;
                `USSU_CS_SOFT:  sel_sample = sw;
                default:        sel_sample = 1'b0;
            endcase
        end
    endfunction

    wire ext_sel;     // external pin clocks the unit
    wire do_sample;   // shift in a bit this cycle
    wire do_update;   // opposite edge on the external clock, else the sample strobe; output latch opens
    wire do_count;    // counter advances this cycle

    assign ext_sel   = (i_clock_source == `USSU_CS_EXT);
    assign do_sample = sel_sample(i_clock_source, i_clock_edge_select_bit,
                                  rise, fall, i_timer_match,
                                  i_clock_strobe); // [R8] [R6]
    assign do_update = ext_sel ?
                       (i_clock_edge_select_bit ? rise : fall) :
                       do_sample; // [R3]
    // external clock counts both edges, internal ones count samples
    assign do_count  = ext_sel ? (rise | fall) : do_sample; // [R7]

    ////////////////////////////////////////////////////////////////////////
    // shift register, counter, flags
    ////////////////////////////////////////////////////////////////////////
    reg [DATA_W-1:0] shift_next;
    reg [CNT_W-1:0]  cnt_next;
    reg              ovf_hit;
    reg              out_latch_reg;   // transparent output latch image
    reg              hold_reg;        // two-wire wait state hold
    reg              fifo_push_reg;   // push received byte into fifo
    reg [DATA_W-1:0] fifo_byte_reg;
    wire             fifo_in_ready;
    wire             fifo_out_valid;
    wire [DATA_W-1:0] fifo_out_data;
    wire             two_wire;
    wire             start_det;

    assign two_wire  = i_wire_mode[1];
    // start: data falls while clock is high
    assign start_det = two_wire & sclk_s & ~din_s & din_d_reg; // [R9]

    // next value of shift register and counter
    always @* begin
        shift_next = o_shift_data_reg;
        cnt_next   = o_cnt;
        ovf_hit    = 1'b0;
        if (i_data_wr) begin
            shift_next = i_data_wdata; // [R1] [R18] [R17]
        end else if (do_sample) begin
            shift_next = {o_shift_data_reg[DATA_W-2:0], din_s}; // [R1] [R12]
        end
        if (i_cnt_wr) begin
            cnt_next = i_cnt_wdata; // [R5] [R17]
        end else if (do_count) begin
            cnt_next = o_cnt + `USSU_CNT_ONE; // [R5] [R22]
            ovf_hit  = (o_cnt == `USSU_CNT_MAX); // [R13] [R22]
        end
    end

    // register state update
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_shift_data_reg <= `USSU_DATA_RST;
            o_cnt            <= `USSU_CNT_RST;
            o_ovf_flag       <= 1'b0;
            o_start_flag     <= 1'b0;
            o_wake           <= 1'b0;
            sclk_d_reg       <= 1'b0;
            din_d_reg        <= 1'b0;
            out_latch_reg    <= 1'b0;
            hold_reg         <= 1'b0;
            fifo_push_reg    <= 1'b0;
            fifo_byte_reg    <= `USSU_DATA_RST;
        end else begin
            o_shift_data_reg <= shift_next;
            o_cnt            <= cnt_next;
            sclk_d_reg       <= sclk_s;
            din_d_reg        <= din_s;
            // set wins over clear
            if (ovf_hit) begin
                o_ovf_flag <= 1'b1; // [R13]
            end else if (i_ovf_clr) begin
                o_ovf_flag <= 1'b0;
            end
            if (start_det) begin
                o_start_flag <= 1'b1; // [R9]
            end else if (i_start_clr) begin
                o_start_flag <= 1'b0;
            end
            // wake pulse for an idle processor
            o_wake <= ovf_hit; // [R21]
            // latch follows msb only on the update edge or a load
            if (do_update || i_data_wr) begin
                out_latch_reg <= shift_next[`USSU_MSB]; // [R3] [R2]
            end
            // hold clock low after start or overflow until flags clear
            if (i_wire_mode == `USSU_WM_TWO_HOLD &&
                (start_det || ovf_hit)) begin
                hold_reg <= 1'b1; // [R10]
            end else if (!o_start_flag && !o_ovf_flag) begin
                hold_reg <= 1'b0;
            end
            // completed byte copied aside so software may lag up to FIFO_DEPTH bytes
            fifo_push_reg <= ovf_hit & fifo_in_ready; // [R20]
            if (ovf_hit) begin
                fifo_byte_reg <= shift_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received byte fifo
    ////////////////////////////////////////////////////////////////////////
    // a full fifo drops the copy; the shift register still holds the byte
    ussu_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (fifo_push_reg),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_byte_reg),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (i_rx_ready & ~o_rx_valid),
        .o_out_data  (fifo_out_data)
    );

    // output stage register for the stream
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_valid <= 1'b0;
            o_rx_data  <= `USSU_DATA_RST;
        end else if (fifo_out_valid && i_rx_ready && !o_rx_valid) begin
            o_rx_valid <= 1'b1;
            o_rx_data  <= fifo_out_data;
        end else begin
            o_rx_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers
    ////////////////////////////////////////////////////////////////////////
    // master clock: a lone toggle request flips the pin, two at once cancel; two flips make a pulse
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_clock_pin    <= 1'b0;
            o_serial_clock_pin_oe <= 1'b0;
            o_data_out            <= 1'b0;
            o_sda_out             <= 1'b0;
            o_sda_oe              <= 1'b0;
        end else begin
            if (hold_reg) begin
                o_serial_clock_pin <= 1'b0; // [R10]
            end else if (i_clock_toggle ^ i_port_clock_toggle) begin
                o_serial_clock_pin <= ~o_serial_clock_pin; // [R14] [R19]
            end
            o_serial_clock_pin_oe <= hold_reg |
                                     (i_wire_mode == `USSU_WM_THREE);
            // three-wire uses data-out, two-wire the shared data pin
            o_data_out <= (i_wire_mode == `USSU_WM_THREE) ?
                          out_latch_reg : 1'b0; // [R2] [R11]
            o_sda_out  <= 1'b0;
            // open drain: drive low only when the latch holds zero
            o_sda_oe   <= two_wire & ~out_latch_reg; // [R2]
        end
    end
endmodule

// ### ussu_checker.sv
`timescale 1ns/10ps
`include "ussu_map.vh"
// port-level checks on the shift unit; one clock domain only
module ussu_checker #(
    parameter DATA_W = 8,
    parameter CNT_W  = 4
) (
    input wire              i_clk,
    input wire              i_rst_n,
    input wire [1:0]        i_wire_mode,
    input wire [1:0]        i_clock_source,
    input wire              i_clock_strobe,
    input wire              i_clock_toggle,
    input wire              i_port_clock_toggle,
    input wire              i_timer_match,
    input wire              i_data_wr,
    input wire [DATA_W-1:0] i_data_wdata,
    input wire [DATA_W-1:0] o_shift_data_reg,
    input wire              i_cnt_wr,
    input wire [CNT_W-1:0]  i_cnt_wdata,
    input wire [CNT_W-1:0]  o_cnt,
    input wire              i_ovf_clr,
    input wire              o_ovf_flag,
    input wire              o_wake,
    input wire              o_serial_clock_pin,
    input wire              o_data_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a write wins over a shift in the same cycle
    data_load_a:
        assert property (i_data_wr
            |=> o_shift_data_reg == $past(i_data_wdata))
        else $error("shift register missed a write");
    cnt_load_a:
        assert property (i_cnt_wr |=> o_cnt == $past(i_cnt_wdata))
        else $error("counter missed a write");
    wrap_flag_a:
        assert property (($past(o_cnt) == `USSU_CNT_MAX && !$past(i_cnt_wr)
            && o_cnt == `USSU_CNT_RST) |-> o_ovf_flag && o_wake)
        else $error("wrap without overflow flag");
    flag_cause_a:
        assert property ($rose(o_ovf_flag)
            |-> o_cnt == `USSU_CNT_RST && o_wake)
        else $error("overflow flag rose without a wrap");
    flag_hold_a:
        assert property (o_ovf_flag && !i_ovf_clr |=> o_ovf_flag)
        else $error("overflow flag dropped without a clear");
    wake_pulse_a:
        assert property (o_wake |=> !o_wake)
        else $error("wake pulse longer than one cycle");
    soft_count_a:
        assert property ((i_clock_strobe && i_wire_mode == `USSU_WM_THREE
            && i_clock_source == `USSU_CS_SOFT && !i_cnt_wr && !i_data_wr)
            |=> o_cnt == $past(o_cnt) + `USSU_CNT_ONE)
        else $error("software strobe not counted");
    soft_shift_a:
        assert property ((i_clock_strobe && i_wire_mode == `USSU_WM_THREE
            && i_clock_source == `USSU_CS_SOFT && !i_cnt_wr && !i_data_wr)
            |=> o_shift_data_reg[DATA_W-1:1]
                == $past(o_shift_data_reg[DATA_W-2:0]))
        else $error("software strobe did not shift");
    timer_count_a:
        assert property ((i_timer_match && i_wire_mode == `USSU_WM_THREE
            && i_clock_source == `USSU_CS_TIMER && !i_cnt_wr && !i_data_wr)
            |=> o_cnt == $past(o_cnt) + `USSU_CNT_ONE)
        else $error("timer match not counted");
    clk_toggle_a:
        assert property (((i_clock_toggle ^ i_port_clock_toggle)
            && i_wire_mode == `USSU_WM_THREE)
            |=> o_serial_clock_pin != $past(o_serial_clock_pin))
        else $error("clock pin did not toggle");
    toggle_cancel_a:
        assert property (i_clock_toggle && i_port_clock_toggle
            |=> $stable(o_serial_clock_pin))
        else $error("two toggles in one cycle moved the pin");
    dout_quiet_a:
        assert property (($past(i_wire_mode) != `USSU_WM_THREE
            && i_wire_mode != `USSU_WM_THREE) |-> !o_data_out)
        else $error("data-out pin driven outside three-wire mode");
endmodule
bind ussu_top ussu_checker #(.DATA_W(DATA_W), .CNT_W(CNT_W)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wire_mode(i_wire_mode),
    .i_clock_source(i_clock_source), .i_clock_strobe(i_clock_strobe),
    .i_clock_toggle(i_clock_toggle), .i_timer_match(i_timer_match),
    .i_port_clock_toggle(i_port_clock_toggle), .i_data_wr(i_data_wr),
    .i_data_wdata(i_data_wdata), .o_shift_data_reg(o_shift_data_reg),
    .i_cnt_wr(i_cnt_wr), .i_cnt_wdata(i_cnt_wdata), .o_cnt(o_cnt),
    .i_ovf_clr(i_ovf_clr), .o_ovf_flag(o_ovf_flag), .o_wake(o_wake),
    .o_serial_clock_pin(o_serial_clock_pin), .o_data_out(o_data_out));

// ### ussu_partner.sv
`timescale 1ns/10ps
// behavioural three-wire slave on the far side; clock comes from the unit
module ussu_partner (
    input  wire       i_sck,
    input  wire       i_es,
    input  wire       i_mosi,
    input  wire       i_load,
    input  wire [7:0] i_byte,
    output reg        o_miso,
    output reg  [7:0] o_rx
);
    reg [7:0] sr;   // outgoing and incoming bits
    integer   cnt;  // samples taken this frame
    initial begin
        o_miso = 1'b0;
        o_rx = 8'h00;
        sr = 8'h00;
        cnt = 8;
    end
    // byte set up at once, well before the first sampling edge
    always @(posedge i_load) begin
        sr = i_byte;
        cnt = 0;
        o_miso = i_byte[7];
    end
    // sample edge is rise in mode 0, fall in mode 1; update on the other
    always @(i_sck) begin
        if (i_sck ^ i_es) begin
            if (cnt < 8) begin
                sr = {sr[6:0], i_mosi};
                cnt = cnt + 1;
                if (cnt == 8) o_rx = sr;
            end
        end else if (cnt < 8) begin
            o_miso = sr[7];
        end else begin
            // released after the byte: no pull, so show a changing level
            o_miso = ~o_miso;
        end
    end
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
`include "ussu_map.vh"
module tb_top;
    reg        i_clk = 1'b0, i_rst_n = 1'b0;
    reg  [1:0] wmode = `USSU_WM_OFF, src = `USSU_CS_NONE;
    reg        es = 1'b0, stb = 1'b0, tog = 1'b0, ptog = 1'b0, tmr = 1'b0;
    reg        dwr = 1'b0, cwr = 1'b0, oclr = 1'b0, rdy = 1'b0, pld = 1'b0;
    reg  [7:0] wdat = 8'h00, pbyte = 8'h00;
    reg  [3:0] cdat = 4'h0;
    reg        ext_sck = 1'b0, sda_sel = 1'b0, sda_lvl = 1'b1;
    wire [7:0] dsr, rxd, prx;
    wire [3:0] cnt;
    wire       ovf, rxv, sck, sck_oe, dout, miso, sck_w, stf, din;
    integer    error_cnt = 0, n_compared = 0, k, got;
    // bench level on the clock line when the unit does not drive it;
    // it idles low like a pull-down
    assign sck_w = sck_oe ? sck : ext_sck;
    // data-in comes from the far end unless a two-wire test drives it
    assign din = sda_sel ? sda_lvl : miso;
    always #10 i_clk = ~i_clk;
    ussu_top DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wire_mode(wmode),
        .i_clock_source(src), .i_clock_edge_select_bit(es),
        .i_clock_strobe(stb), .i_clock_toggle(tog), .i_timer_match(tmr),
        .i_port_clock_toggle(ptog), .i_data_wr(dwr), .i_data_wdata(wdat),
        .o_shift_data_reg(dsr), .i_cnt_wr(cwr), .i_cnt_wdata(cdat),
        .o_cnt(cnt), .i_ovf_clr(oclr), .o_ovf_flag(ovf), .i_start_clr(oclr),
        .o_start_flag(stf), .o_wake(), .o_rx_valid(rxv), .i_rx_ready(rdy),
        .o_rx_data(rxd), .i_serial_data_in(din), .i_serial_clock_pin(sck_w),
        .o_serial_clock_pin(sck), .o_serial_clock_pin_oe(sck_oe),
        .o_data_out(dout), .o_sda_out(), .o_sda_oe());
    ussu_partner far_end (.i_sck(sck_w), .i_es(es), .i_mosi(dout),
        .i_load(pld), .i_byte(pbyte), .o_miso(miso), .o_rx(prx));
    task tick(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task cmp8(input [95:0] what, input [7:0] exp, input [7:0] seen);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // load shift register, zero the counter and clear the flag together
    task load(input [7:0] d);
        begin
            @(posedge i_clk);
            dwr <= 1'b1; wdat <= d; cwr <= 1'b1; cdat <= 4'h0; oclr <= 1'b1;
            @(posedge i_clk);
            dwr <= 1'b0; cwr <= 1'b0; oclr <= 1'b0;
        end
    endtask
    // one-cycle pulse: 0 toggle bit, 1 port path, 2 both, 3 strobe, 4 timer
    task pulse(input integer sel);
        begin
            @(posedge i_clk);
            tog <= (sel == 0 || sel == 2); ptog <= (sel == 1 || sel == 2);
            stb <= (sel == 3); tmr <= (sel == 4);
            @(posedge i_clk);
            tog <= 1'b0; ptog <= 1'b0; stb <= 1'b0; tmr <= 1'b0;
        end
    endtask
    // full byte exchange with the unit as clock master
    task xfer(input [7:0] dv, input [7:0] pv, input e, input integer half,
              input integer path);
        integer i;
        begin
            es <= e; src <= `USSU_CS_EXT; pbyte <= pv; pld <= 1'b1;
            load(dv);
            pld <= 1'b0;
            tick(half);
            for (i = 0; i < 16; i = i + 1) begin
                pulse(path);
                tick(half);
                if (i == 7 && half > 4)
                    cmp8("edge count", 8'h08, {4'h0, cnt});
            end
            tick(4);
            cmp8("overflow", 8'h01, {7'h00, ovf});
            cmp8("count", 8'h00, {4'h0, cnt});
            cmp8("rx byte", pv, dsr);
            if (half > 4) cmp8("far rx", dv, prx);
        end
    endtask
    task results;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        $display("watchdog expired");
        results;
    end
    initial begin
        tick(6);
        i_rst_n <= 1'b1;
        tick(3);
        wmode <= `USSU_WM_THREE;
        pulse(0); tick(2); cmp8("clock pin", 8'h01, {7'h00, sck});
        pulse(1); tick(2); cmp8("clock pin", 8'h00, {7'h00, sck});
        pulse(2); tick(2); cmp8("clock pin", 8'h00, {7'h00, sck});
        $display("test clock toggle done");
        // nine bytes against a stalled consumer: the fifo keeps eight
        for (k = 0; k < 9; k = k + 1)
            xfer(8'h5a ^ {k[3:0], ~k[3:0]}, {k[3:0], ~k[3:0]}, k[0], 6, k[1]);
        got = 0;
        rdy <= 1'b1;
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (rxv === 1'b1) begin
                cmp8("fifo byte", {got[3:0], ~got[3:0]}, rxd);
                got = got + 1;
            end
        end
        cmp8("fifo count", 8'h08, got[7:0]);
        $display("test exchange and fifo done");
        xfer(8'h96, 8'h69, 1'b0, 2, 0);
        $display("test prompt exchange done");
        load(8'h00);
        src <= `USSU_CS_SOFT;
        repeat (8) pulse(3);
        tick(2); cmp8("count", 8'h08, {4'h0, cnt});
        src <= `USSU_CS_NONE;
        pulse(3);
        tick(2); cmp8("count", 8'h08, {4'h0, cnt});
        src <= `USSU_CS_TIMER;
        repeat (8) pulse(4);
        tick(2); cmp8("count", 8'h00, {4'h0, cnt});
        cmp8("overflow", 8'h01, {7'h00, ovf});
        $display("test strobe and timer done");
        // two-wire with hold: data falls while the clock line is high
        wmode <= `USSU_WM_TWO_HOLD;
        ext_sck <= 1'b1;
        sda_sel <= 1'b1;
        tick(4);
        sda_lvl <= 1'b0;
        tick(6);
        cmp8("start flag", 8'h01, {7'h00, stf});
        cmp8("clock oe", 8'h01, {7'h00, sck_oe});
        cmp8("clock pin", 8'h00, {7'h00, sck});
        // clearing both flags lets the held clock line go
        load(8'h00);
        tick(4);
        cmp8("start flag", 8'h00, {7'h00, stf});
        cmp8("clock oe", 8'h00, {7'h00, sck_oe});
        $display("test start and hold done");
        results;
    end
endmodule
